// >>> logic/gnss_power_mode_sequencer.v
// Power-mode sequencer with serial command front end and AXI4-Lite registers
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`include "gnss_pwr_defines.vh"
module gnss_power_mode_sequencer #(
  parameter MS_CYC     = `MS_CYCLES,
  parameter WARMUP     = `WARMUP_MS,
  parameter FIT_WAIT   = `FITNESS_WAIT_MS,
  parameter ORBIT_LIFE = `ORBIT_LIFE_MS
) (
  input  wire        core_clk_i,
  input  wire        arst_n_i,
  input  wire [4:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [4:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        host_power_enable_i,
  input  wire        uart_rx_i,
  output wire        uart_tx_o,
  input  wire        power_switch_i,
  output wire        power_switch_o,
  output wire        power_switch_oe_o,
  input  wire        fix_valid_i,
  input  wire        ephemeris_rx_i,
  output wire        nav_run_o,
  output wire        orbit_aid_use_o,
  output wire        fitness_active_o
);
  // ****************************************************************
  // Modes
  // ****************************************************************
  localparam [3:0] M_FULL = 4'h0, M_STBY = 4'h1, M_PERM = 4'h2, M_WARM = 4'h3,
                   M_PACT = 4'h4, M_PSLP = 4'h5, M_ASRUN = 4'h6, M_ASSLP = 4'h7,
                   M_ABRUN = 4'h8, M_ABSLP = 4'h9;
  reg  [3:0]  mode_q;
  reg         per_bkp_q, retry_q, fix_seen_q;
  reg  [31:0] act_q, slp_q, ract_q, rslp_q, tmr_q;
  reg  [31:0] ctrl_q, adapt_q, err_q;
  reg         fit_en_q, fit_act_q, fit_fix_q, aid_valid_q;
  reg  [31:0] fit_tmr_q, orbit_tmr_q;
  reg  [15:0] ms_cnt_q;
  wire        ms_tick = (ms_cnt_q == MS_CYC[15:0] - 16'h0001);
  // ****************************************************************
  // Pin synchronisers: change accepted when stages two and three agree
  // ****************************************************************
  reg [2:0] rx_s_q, en_s_q;
  reg       rx_q, en_q;
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_s_q <= 3'h7;
      en_s_q <= 3'h0;
      rx_q   <= 1'b1;
      en_q   <= 1'b0;
    end else begin
      rx_s_q <= {rx_s_q[1:0], uart_rx_i};
      en_s_q <= {en_s_q[1:0], host_power_enable_i};
      if (rx_s_q[1] == rx_s_q[2]) rx_q <= rx_s_q[2];
      if (en_s_q[1] == en_s_q[2]) en_q <= en_s_q[2];
    end
  end
  // ****************************************************************
  // Baud selection and UART receiver, 8N1
  // ****************************************************************
  reg [12:0] bdiv;
  always @* begin
    case (ctrl_q[`CTRL_BAUD_MSB:`CTRL_BAUD_LSB])
      3'h0:    bdiv = `DIV_4800;
      3'h1:    bdiv = `DIV_9600;
      3'h2:    bdiv = `DIV_14400;
      3'h3:    bdiv = `DIV_19200;
      3'h4:    bdiv = `DIV_38400;
      3'h5:    bdiv = `DIV_57600;
      3'h6:    bdiv = `DIV_115200;
      default: bdiv = `DIV_115200;
    endcase
  end
  reg [12:0] rx_cnt_q;
  reg [3:0]  rx_bit_q;
  reg [7:0]  rx_sh_q;
  reg        rx_busy_q, rx_stb_q;
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_cnt_q  <= 13'h0000;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 8'h00;
      rx_busy_q <= 1'b0;
      rx_stb_q  <= 1'b0;
    end else begin
      rx_stb_q <= 1'b0;
      if (!rx_busy_q) begin
        if (!rx_q) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q  <= {1'b0, bdiv[12:1]};
          rx_bit_q  <= 4'h0;
        end
      end else if (rx_cnt_q != 13'h0000) begin
        rx_cnt_q <= rx_cnt_q - 13'h0001;
      end else begin
        rx_cnt_q <= bdiv - 13'h0001;
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0) begin
          if (rx_q) rx_busy_q <= 1'b0; // False start bit
        end else if (rx_bit_q == 4'h9) begin
          rx_busy_q <= 1'b0;
          rx_stb_q  <= rx_q; // Framing error drops the byte
        end else begin
          rx_sh_q <= {rx_q, rx_sh_q[7:1]};
        end
      end
    end
  end
  wire in_backup = (mode_q == M_PERM) || (mode_q == M_ABSLP) || (mode_q == M_PSLP && per_bkp_q);
  wire rx_byte   = rx_stb_q && !in_backup;
  // ****************************************************************
  // Sentence parser: "$" talker "," decimal fields "*" hex checksum CR LF
  // ****************************************************************
  reg         p_on_q, p_cs_q, p_bad_q, cmd_stb_q;
  reg  [2:0]  p_fld_q;
  reg  [3:0]  p_pos_q;
  reg  [1:0]  p_ncs_q;
  reg  [7:0]  p_xor_q, p_cs_val_q;
  reg  [31:0] fld_q [0:5];
  wire        is_dig = (rx_sh_q >= 8'h30) && (rx_sh_q <= 8'h39);
  wire [3:0]  hexv   = is_dig ? rx_sh_q[3:0] : (rx_sh_q[3:0] + 4'h9);
  reg  [7:0]  talk_ch;
  always @* begin
    case (p_pos_q)
      4'h0:    talk_ch = 8'h50;
      4'h1:    talk_ch = 8'h4D;
      4'h2:    talk_ch = 8'h54;
      default: talk_ch = 8'h4B;
    endcase
  end
  integer k;
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      p_on_q <= 1'b0; p_cs_q <= 1'b0; p_bad_q <= 1'b0; cmd_stb_q <= 1'b0;
      p_fld_q <= 3'h0; p_pos_q <= 4'h0; p_ncs_q <= 2'h0;
      p_xor_q <= 8'h00; p_cs_val_q <= 8'h00; err_q <= 32'h0000_0000;
      for (k = 0; k < 6; k = k + 1) fld_q[k] <= 32'h0000_0000;
    end else begin
      cmd_stb_q <= 1'b0;
      if (rx_byte) begin
        if (rx_sh_q == 8'h24) begin
          p_on_q <= 1'b1; p_cs_q <= 1'b0; p_bad_q <= 1'b0;
          p_fld_q <= 3'h0; p_pos_q <= 4'h0; p_ncs_q <= 2'h0;
          p_xor_q <= 8'h00; p_cs_val_q <= 8'h00;
          for (k = 0; k < 6; k = k + 1) fld_q[k] <= 32'h0000_0000;
        end else if (p_on_q && p_cs_q) begin
          if (rx_sh_q == 8'h0A) begin
            p_on_q <= 1'b0;
            if (!p_bad_q && p_ncs_q == 2'h2 && p_cs_val_q == p_xor_q)
              cmd_stb_q <= 1'b1;
            else
              err_q <= err_q + 32'h0000_0001;
          end else if (rx_sh_q != 8'h0D && p_ncs_q != 2'h2) begin
            p_cs_val_q <= {p_cs_val_q[3:0], hexv};
            p_ncs_q    <= p_ncs_q + 2'h1;
          end
        end else if (p_on_q) begin
          if (rx_sh_q == 8'h2A) begin
            p_cs_q <= 1'b1;
          end else begin
            p_xor_q <= p_xor_q ^ rx_sh_q;
            if (p_pos_q < 4'h4) begin
              p_pos_q <= p_pos_q + 4'h1;
              if (rx_sh_q != talk_ch) p_bad_q <= 1'b1;
            end else if (rx_sh_q == 8'h2C) begin
              if (p_fld_q == 3'h5) p_bad_q <= 1'b1;
              else p_fld_q <= p_fld_q + 3'h1;
            end else if (is_dig) begin
              fld_q[p_fld_q] <= fld_q[p_fld_q] * 32'h0000_000A
                                + {28'h0000000, rx_sh_q[3:0]};
            end else if (rx_sh_q != 8'h20) begin
              p_bad_q <= 1'b1;
            end
          end
        end
      end
    end
  end
  wire [31:0] c_num  = fld_q[0];
  wire [31:0] c_type = fld_q[1];
  wire cmd_per = cmd_stb_q && c_num == `CMD_PERIODIC;
  wire exit_ok = (mode_q == M_STBY) || (mode_q == M_WARM) || (mode_q == M_PACT)
              || (mode_q == M_PSLP && !per_bkp_q) || (mode_q == M_ASRUN)
              || (mode_q == M_ASSLP) || (mode_q == M_ABRUN);
  reg reply_req_q;
  // ****************************************************************
  // Mode sequencer with millisecond timebase
  // ****************************************************************
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_q <= M_FULL; per_bkp_q <= 1'b0; retry_q <= 1'b0; fix_seen_q <= 1'b0;
      act_q <= 32'h0000_0000; slp_q <= 32'h0000_0000;
      ract_q <= 32'h0000_0000; rslp_q <= 32'h0000_0000;
      tmr_q <= 32'h0000_0000; ms_cnt_q <= 16'h0000; reply_req_q <= 1'b0;
    end else begin
      ms_cnt_q <= ms_tick ? 16'h0000 : ms_cnt_q + 16'h0001;
      if (ms_tick && tmr_q != 32'h0000_0000) tmr_q <= tmr_q - 32'h0000_0001;
      reply_req_q <= 1'b0;
      if (fix_valid_i) fix_seen_q <= 1'b1;
      if (cmd_per && mode_q == M_FULL && c_type == `TYPE_PERM_BKP && !en_q) begin
        mode_q <= M_PERM;
      end else if (cmd_per && mode_q == M_FULL
                   && (c_type == `TYPE_PER_BKP || c_type == `TYPE_PER_STBY)) begin
        mode_q <= M_WARM;
        per_bkp_q <= (c_type == `TYPE_PER_BKP);
        act_q <= fld_q[2]; slp_q <= fld_q[3]; ract_q <= fld_q[4]; rslp_q <= fld_q[5];
        retry_q <= 1'b0; tmr_q <= WARMUP;
      end else if (cmd_per && mode_q == M_FULL && c_type == `TYPE_AL_STBY) begin
        mode_q <= M_ASRUN;
        reply_req_q <= 1'b1;
        fix_seen_q <= 1'b0;
      end else if (cmd_per && mode_q == M_FULL && c_type == `TYPE_AL_BKP) begin
        mode_q <= M_ABRUN;
        fix_seen_q <= 1'b0;
      end else if (cmd_per && c_type == `TYPE_FULL && exit_ok) begin
        mode_q <= M_FULL;
      end else if (cmd_stb_q && c_num == `CMD_STANDBY && c_type == `TYPE_FULL
                   && mode_q == M_FULL) begin
        mode_q <= M_STBY;
      end else begin
        case (mode_q)
          M_STBY:  if (rx_byte) mode_q <= M_FULL;
          M_PERM:  if (en_q) mode_q <= M_FULL;
          M_WARM:  if (tmr_q == 32'h0000_0000) begin
                     mode_q <= M_PACT; tmr_q <= act_q; fix_seen_q <= 1'b0;
                   end
          M_PACT:  if (tmr_q == 32'h0000_0000) begin
                     mode_q  <= M_PSLP;
                     retry_q <= !fix_seen_q;
                     tmr_q   <= fix_seen_q ? slp_q : rslp_q;
                   end
          M_PSLP:  if (tmr_q == 32'h0000_0000) begin
                     mode_q <= M_PACT; fix_seen_q <= 1'b0;
                     tmr_q  <= retry_q ? ract_q : act_q;
                   end
          M_ASRUN, M_ABRUN:
                   if (fix_seen_q || fix_valid_i) begin
                     mode_q <= (mode_q == M_ASRUN) ? M_ASSLP : M_ABSLP;
                     tmr_q  <= adapt_q;
                   end
          M_ASSLP, M_ABSLP:
                   if (tmr_q == 32'h0000_0000) begin
                     mode_q <= (mode_q == M_ASSLP) ? M_ASRUN : M_ABRUN;
                     fix_seen_q <= 1'b0;
                   end
          default: ;
        endcase
      end
    end
  end
  assign nav_run_o = (mode_q == M_FULL) || (mode_q == M_WARM) || (mode_q == M_PACT)
                  || (mode_q == M_ASRUN) || (mode_q == M_ABRUN);
  assign power_switch_o    = 1'b0;
  assign power_switch_oe_o = in_backup;
  // ****************************************************************
  // Fitness duty cycle and orbit-prediction aiding
  // ****************************************************************
  wire cmd_fit = cmd_stb_q && c_num == `CMD_FITNESS;
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fit_en_q <= 1'b0; fit_act_q <= 1'b0; fit_fix_q <= 1'b0;
      fit_tmr_q <= 32'h0000_0000; aid_valid_q <= 1'b0; orbit_tmr_q <= 32'h0000_0000;
    end else begin
      if (cmd_fit) begin
        fit_en_q  <= (c_type == 32'h0000_0001);
        fit_act_q <= 1'b0;
        fit_fix_q <= 1'b0;
        fit_tmr_q <= FIT_WAIT;
      end else if (fit_en_q && !fit_fix_q) begin
        fit_fix_q <= fix_valid_i;
      end else if (fit_en_q && ms_tick) begin
        if (fit_tmr_q == 32'h0000_0000) fit_act_q <= 1'b1;
        else fit_tmr_q <= fit_tmr_q - 32'h0000_0001;
      end
      if (ephemeris_rx_i) begin
        aid_valid_q <= 1'b1; orbit_tmr_q <= ORBIT_LIFE;
      end else if (ms_tick && aid_valid_q) begin
        if (orbit_tmr_q == 32'h0000_0000) aid_valid_q <= 1'b0;
        else orbit_tmr_q <= orbit_tmr_q - 32'h0000_0001;
      end
    end
  end
  assign fitness_active_o = fit_act_q && nav_run_o;
  // Prediction fills in only while live satellite data are missing
  assign orbit_aid_use_o  = ctrl_q[`CTRL_AID_BIT] && aid_valid_q && !fix_valid_i;
  // ****************************************************************
  // UART transmitter: acknowledge sentence first, then software bytes
  // ****************************************************************
  reg [7:0] ack_ch;
  reg [4:0] ack_idx_q;
  always @* begin
    case (ack_idx_q)
      5'h00: ack_ch = 8'h24; 5'h01: ack_ch = 8'h50; 5'h02: ack_ch = 8'h4D;
      5'h03: ack_ch = 8'h54; 5'h04: ack_ch = 8'h4B; 5'h05: ack_ch = 8'h30;
      5'h06: ack_ch = 8'h30; 5'h07: ack_ch = 8'h31; 5'h08: ack_ch = 8'h2C;
      5'h09: ack_ch = 8'h32; 5'h0A: ack_ch = 8'h32; 5'h0B: ack_ch = 8'h35;
      5'h0C: ack_ch = 8'h2C; 5'h0D: ack_ch = 8'h33; 5'h0E: ack_ch = 8'h2A;
      5'h0F: ack_ch = 8'h33; 5'h10: ack_ch = 8'h35; 5'h11: ack_ch = 8'h0D;
      default: ack_ch = 8'h0A;
    endcase
  end
  reg [9:0]  tx_sh_q;
  reg [3:0]  tx_bit_q;
  reg [12:0] tx_cnt_q;
  reg        tx_busy_q, ack_on_q, tx_wr_q;
  reg [7:0]  tx_wdat_q;
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_sh_q <= 10'h3FF; tx_bit_q <= 4'h0; tx_cnt_q <= 13'h0000;
      tx_busy_q <= 1'b0; ack_on_q <= 1'b0; ack_idx_q <= 5'h00;
    end else begin
      if (reply_req_q) begin
        ack_on_q <= 1'b1; ack_idx_q <= 5'h00;
      end
      if (tx_busy_q) begin
        if (tx_cnt_q != 13'h0000) begin
          tx_cnt_q <= tx_cnt_q - 13'h0001;
        end else begin
          tx_cnt_q <= bdiv - 13'h0001;
          tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
          tx_bit_q <= tx_bit_q + 4'h1;
          if (tx_bit_q == 4'h9) tx_busy_q <= 1'b0;
        end
      end else if (ack_on_q && !reply_req_q) begin
        tx_sh_q <= {1'b1, ack_ch, 1'b0}; tx_busy_q <= 1'b1;
        tx_bit_q <= 4'h0; tx_cnt_q <= bdiv - 13'h0001;
        ack_idx_q <= ack_idx_q + 5'h01;
        if (ack_idx_q == 5'h12) ack_on_q <= 1'b0;
      end else if (tx_wr_q && nav_run_o) begin
        tx_sh_q <= {1'b1, tx_wdat_q, 1'b0}; tx_busy_q <= 1'b1;
        tx_bit_q <= 4'h0; tx_cnt_q <= bdiv - 13'h0001;
      end
    end
  end
  assign uart_tx_o = tx_sh_q[0];
  wire tx_idle = !tx_busy_q && !ack_on_q && !reply_req_q;
  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  reg        aw_q, w_q, bv_q, rv_q;
  reg [4:0]  awa_q;
  reg [31:0] wd_q, rd_q;
  reg [3:0]  ws_q;
  reg [1:0]  br_q, rr_q;
  wire do_wr = aw_q && w_q && !bv_q;
  wire wmap  = (awa_q == `REG_CTRL) || (awa_q == `REG_TX_DATA) || (awa_q == `REG_ADAPT_SLEEP)
            || (awa_q == `REG_STATUS) || (awa_q == `REG_ERR_COUNT);
  wire [31:0] status = {22'h000000, power_switch_i, en_q, !tx_idle,
                        fit_act_q, fit_en_q, retry_q, mode_q};
  integer b;
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b0; rv_q <= 1'b0;
      awa_q <= 5'h00; wd_q <= 32'h0000_0000; ws_q <= 4'h0;
      br_q <= 2'h0; rr_q <= 2'h0; rd_q <= 32'h0000_0000;
      ctrl_q <= `CTRL_RESET; adapt_q <= `ADAPT_SLEEP_RST;
      tx_wr_q <= 1'b0; tx_wdat_q <= 8'h00;
    end else begin
      if (s_axi_awvalid && !aw_q) begin
        aw_q <= 1'b1; awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q) begin
        w_q <= 1'b1; wd_q <= s_axi_wdata; ws_q <= s_axi_wstrb;
      end
      if (tx_wr_q && tx_idle && nav_run_o) tx_wr_q <= 1'b0;
      if (do_wr) begin
        aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b1;
        br_q <= wmap ? 2'h0 : 2'h2;
        for (b = 0; b < 4; b = b + 1) begin
          if (ws_q[b] && awa_q == `REG_CTRL) ctrl_q[b*8 +: 8] <= wd_q[b*8 +: 8];
          if (ws_q[b] && awa_q == `REG_ADAPT_SLEEP) adapt_q[b*8 +: 8] <= wd_q[b*8 +: 8];
        end
        // A byte written while one is still waiting is dropped
        if (awa_q == `REG_TX_DATA && ws_q[0] && !tx_wr_q) begin
          tx_wr_q <= 1'b1; tx_wdat_q <= wd_q[7:0];
        end
      end else if (bv_q && s_axi_bready) begin
        bv_q <= 1'b0;
      end
      if (cmd_fit && c_type == 32'h0000_0001)
        ctrl_q[`CTRL_AID_BIT] <= 1'b0;
      if (s_axi_arvalid && !rv_q) begin
        rv_q <= 1'b1; rr_q <= 2'h0;
        case (s_axi_araddr)
          `REG_CTRL:        rd_q <= ctrl_q;
          `REG_STATUS:      rd_q <= status;
          `REG_TX_DATA:     rd_q <= {24'h000000, tx_wdat_q};
          `REG_ADAPT_SLEEP: rd_q <= adapt_q;
          `REG_ERR_COUNT:   rd_q <= err_q;
          default: begin
            rd_q <= 32'h0000_0000; rr_q <= 2'h2;
          end
        endcase
      end else if (rv_q && s_axi_rready) begin
        rv_q <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_q;
  assign s_axi_wready  = !w_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;
endmodule // gnss_power_mode_sequencer

// >>> logic/gnss_pwr_defines.vh
// Offsets, field positions, reset values and timing counts of the power-mode sequencer
`ifndef GNSS_PWR_DEFINES_VH
`define GNSS_PWR_DEFINES_VH
// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define REG_CTRL        5'h00
`define REG_STATUS      5'h04
`define REG_TX_DATA     5'h08
`define REG_ADAPT_SLEEP 5'h0C
`define REG_ERR_COUNT   5'h10
`define CTRL_AID_BIT    0
`define CTRL_BAUD_LSB   4
`define CTRL_BAUD_MSB   6
`define CTRL_RESET      32'h0000_0011
`define ADAPT_SLEEP_RST 32'h0000_2710
// ****************************************************************
// Timing
// ****************************************************************
`define CLK_HZ          25000000
`define MS_CYCLES       (`CLK_HZ / 1000)
`define WARMUP_MS       120000
`define FITNESS_WAIT_MS 60000
`define ORBIT_LIFE_MS   259200000
// Bit periods in clock cycles for 4800..115200 baud
`define DIV_4800        13'h1458
`define DIV_9600        13'h0A2C
`define DIV_14400       13'h06C8
`define DIV_19200       13'h0516
`define DIV_38400       13'h028B
`define DIV_57600       13'h01B2
`define DIV_115200      13'h00D9
// ****************************************************************
// Command numbers and types
// ****************************************************************
`define CMD_PERIODIC    32'h0000_00E1
`define CMD_STANDBY     32'h0000_00A1
`define CMD_FITNESS     32'h0000_0106
`define TYPE_FULL       32'h0000_0000
`define TYPE_PER_BKP    32'h0000_0001
`define TYPE_PER_STBY   32'h0000_0002
`define TYPE_PERM_BKP   32'h0000_0004
`define TYPE_AL_STBY    32'h0000_0008
`define TYPE_AL_BKP     32'h0000_0009
`endif

// >>> tb/gnss_pwr_sva.sv
// Port checker for the power-mode sequencer
module gnss_pwr_sva (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic host_power_enable_i,
  input wire logic power_switch_o,
  input wire logic power_switch_oe_o,
  input wire logic nav_run_o,
  input wire logic orbit_aid_use_o,
  input wire logic fix_valid_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // ********
  // Power switch, backup and orbit aid
  // ********
  chk_oe_needs_low: assert property (
    $rose(power_switch_oe_o) |-> !$past(host_power_enable_i, 3))
    else $error("Switch pulled with host enable high");
  chk_switch_low: assert property (
    power_switch_oe_o |-> power_switch_o == 1'b0)
    else $error("Switch output not low while enabled");
  chk_backup_no_nav: assert property (
    power_switch_oe_o |-> !nav_run_o)
    else $error("Navigation runs in backup");
  chk_wake_by_enable: assert property (
    $fell(power_switch_oe_o) |-> $past(host_power_enable_i, 2))
    else $error("Backup left without host enable");
  chk_stay_backup: assert property (
    (power_switch_oe_o && !host_power_enable_i) [*4] |=> power_switch_oe_o)
    else $error("Backup dropped while enable low");
  chk_aid_no_fix: assert property (
    orbit_aid_use_o |-> !fix_valid_i)
    else $error("Orbit aid used with a fix present");
  // ********
  // Register bus
  // ********
  chk_read_next: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read data not one cycle after address");
  chk_read_retire: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("Read data still offered after rready");
  cover property ($rose(power_switch_oe_o));
  cover property ($fell(power_switch_oe_o));
  cover property ($rose(orbit_aid_use_o));
endmodule // gnss_pwr_sva

bind gnss_power_mode_sequencer gnss_pwr_sva u_sva (.*);

// >>> tb/host_model.sv
// Host model: serial sender, power-enable line and pulled-up switch wire
module host_model #(
  parameter int BIT_CYC = 217
) (
  input  wire logic core_clk_i,
  input  wire logic power_switch_oe_i,
  output logic      tx_o,
  output logic      enable_o,
  output wire logic switch_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released line floats up to the pull-up level
  assign switch_o = !power_switch_oe_i;
  initial begin
    tx_o = 1'b1;
    enable_o = 1'b1;
  end
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction
  // No flow control: bytes go back to back, LSB first, 8N1
  task automatic put_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      tx_o <= f[i];
      repeat (BIT_CYC) @(posedge core_clk_i);
    end
  endtask
  // Checksum covers what lies between dollar and asterisk
  task automatic send(input string body);
    logic [7:0] cs;
    cs = 8'h00;
    put_byte(8'h24);
    for (int i = 0; i < body.len(); i++) begin
      cs ^= body[i];
      put_byte(body[i]);
    end
    put_byte(8'h2A);
    put_byte(hx(cs[7:4]));
    put_byte(hx(cs[3:0]));
    put_byte(8'h0D);
    put_byte(8'h0A);
  endtask
  // Enable held low before permanent backup; raising it is the only wake from it
  task automatic set_en(input logic v);
    enable_o <= v;
  endtask
endmodule // host_model

// >>> tb/testbench.sv
// Self-checking bench for the power-mode sequencer
`include "gnss_pwr_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_i = 1'b0, arst_n_i = 1'b0, fix_valid_i = 1'b0, ephemeris_rx_i = 1'b0;
  logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, tx_seen = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        host_power_enable_i, uart_rx_i, uart_tx_o, power_switch_i, power_switch_o;
  logic        power_switch_oe_o, nav_run_o, orbit_aid_use_o, fitness_active_o;
  int          fails = 0, num_checks = 0;
  // Rows: address, expected data, expected response
  logic [38:0] rows [5] = '{{`REG_CTRL, `CTRL_RESET, 2'h0}, {`REG_STATUS, 32'h0000_0300, 2'h0},
    {`REG_ADAPT_SLEEP, `ADAPT_SLEEP_RST, 2'h0}, {`REG_ERR_COUNT, 32'h0000_0000, 2'h0},
    {5'h14, 32'h0000_0000, 2'h2}};
  always #20 core_clk_i = ~core_clk_i;
  always @(negedge uart_tx_o) tx_seen = 1'b1;
  gnss_power_mode_sequencer #(.MS_CYC(10), .WARMUP(3), .FIT_WAIT(2), .ORBIT_LIFE(5)) DUT (
    .core_clk_i, .arst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .host_power_enable_i, .uart_rx_i, .uart_tx_o, .power_switch_i,
    .power_switch_o, .power_switch_oe_o, .fix_valid_i, .ephemeris_rx_i, .nav_run_o,
    .orbit_aid_use_o, .fitness_active_o);
  host_model host (.core_clk_i, .power_switch_oe_i(power_switch_oe_o),
    .tx_o(uart_rx_i), .enable_o(host_power_enable_i), .switch_o(power_switch_i));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge core_clk_i); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge core_clk_i); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge core_clk_i); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [4:0] a);
    @(posedge core_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk_i); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic do_reset();
    arst_n_i <= 1'b0;
    repeat (12) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
  endtask
  task automatic close_out();
    if (fails == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    do_reset();
    chk(fitness_active_o, 1'b0);
    foreach (rows[i]) begin
      axr(rows[i][38:34]);
      chk(rd, rows[i][33:2]);
      chk(resp, rows[i][1:0]);
    end
    axw(5'h14, 32'h0000_0001);
    chk(resp, 2'h2);
    // Fastest rate keeps each sentence near 33k cycles
    axw(`REG_CTRL, 32'h0000_0061);
    axr(`REG_CTRL);
    chk(rd, 32'h0000_0061);
    s_axi_wstrb <= 4'h1;
    axw(`REG_ADAPT_SLEEP, 32'hFFFF_FF05);
    s_axi_wstrb <= 4'hF;
    axr(`REG_ADAPT_SLEEP);
    chk(rd, 32'h0000_2705);
    ephemeris_rx_i <= 1'b1;
    @(posedge core_clk_i);
    ephemeris_rx_i <= 1'b0;
    repeat (25) @(posedge core_clk_i);
    chk(orbit_aid_use_o, 1'b1);
    fix_valid_i <= 1'b1;
    @(posedge core_clk_i);
    chk(orbit_aid_use_o, 1'b0);
    fix_valid_i <= 1'b0;
    repeat (60) @(posedge core_clk_i);
    chk(orbit_aid_use_o, 1'b0);
    tx_seen = 1'b0;
    host.send("PMTK225,8");
    chk(tx_seen, 1'b1);
    axr(`REG_STATUS);
    chk(rd[3:0], 4'h6);
    do_reset();
    axw(`REG_CTRL, 32'h0000_0061);
    host.set_en(1'b0);
    repeat (8) @(posedge core_clk_i);
    tx_seen = 1'b0;
    host.send("PMTK225,4");
    repeat (4) @(posedge core_clk_i);
    chk(power_switch_oe_o, 1'b1);
    chk(nav_run_o, 1'b0);
    // An empty framed sentence would bump the error count if it were heard
    host.put_byte(8'h24);
    host.put_byte(8'h2A);
    host.put_byte(8'h0A);
    axr(`REG_STATUS);
    chk(rd, 32'h0000_0002);
    chk(tx_seen, 1'b0);
    axr(`REG_ERR_COUNT);
    chk(rd, 32'h0000_0000);
    host.set_en(1'b1);
    repeat (8) @(posedge core_clk_i);
    chk(power_switch_oe_o, 1'b0);
    chk(nav_run_o, 1'b1);
    tx_seen = 1'b0;
    axw(`REG_TX_DATA, 32'h0000_0055);
    repeat (8) @(posedge core_clk_i);
    chk(tx_seen, 1'b1);
    close_out();
  end
  // Two sentences plus a few bytes need about 72k cycles
  initial begin
    repeat (100000) @(posedge core_clk_i);
    fails++;
    close_out();
  end
endmodule // testbench
